// File: core/ieu_dispatch_unit.sv
// Interrupt and exception dispatch unit of the processor core.
`timescale 1ns/1ps
`include "ieu_params.svh"
module ieu_dispatch_unit import ieu_pkg::*;
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // Instruction sequencing
    input wire logic BOUNDARY_IN,
    input wire logic STRING_STEP_IN,
    input wire logic [31:0] CUR_ADDR_IN,
    input wire logic [31:0] NEXT_ADDR_IN,
    input wire logic PROT_MODE_IN,
    input wire logic ENTRY_DONE_IN,
    input wire logic RETURN_FROM_INTERRUPT_IN,
    input wire logic SET_IF_IN,
    input wire logic CLEAR_IF_IN,
    // Internal events
    input wire logic EXC_VALID_IN,
    input wire logic [7:0] EXC_VECTOR_IN,
    input wire logic SWI_VALID_IN,
    input wire logic SWI_ONE_BYTE_IN,
    input wire logic [7:0] SWI_VECTOR_IN,
    input wire logic DBG_TRAP_IN,
    input wire logic DBG_FAULT_IN,
    input wire logic FETCH_FAULT_IN,
    input wire logic [7:0] FETCH_VECTOR_IN,
    // External interrupt controller
    input wire logic MASKABLE_IRQ_IN,
    input wire logic NONMASKABLE_IRQ_IN,
    input wire logic ACK_VALID_IN,
    input wire logic [7:0] ACK_VECTOR_IN,
    output logic INTA_OUT,
    // Dispatch results
    output logic DISPATCH_OUT,
    output logic [7:0] VECTOR_OUT,
    output ieu_class_type CLASS_OUT,
    output logic [31:0] RETURN_ADDR_OUT,
    output logic [10:0] TABLE_OFFSET_OUT,
    output logic IRQ_ENABLE_OUT,
    output logic NMI_ACTIVE_OUT,
    output logic RESUME_OUT,
    output logic [31:0] RESUME_ADDR_OUT,
    output logic SHUTDOWN_OUT
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    ieu_state_type st_ff, nxt_st;
    logic if_ff, nmi_prev_ff, nmi_pend_ff, nmi_active_ff, pf_again_ff;
    logic [7:0] enter_vec_ff;
    logic [2:0] sp_ff;
    ieu_class_type cls_sel;
    logic shut_ff;
    ieu_frame_if frm ();

    // The store reads one cycle ahead, so a popped frame is ready in the restore state.
    ieu_frame_store u_store
    (
        .clk_in(CLK_IN),
        .frm(frm)
    );

    // --------------------------------------------------------------
    // Event selection
    // --------------------------------------------------------------
    wire idle = st_ff == ST_IDLE;
    wire at_bnd = BOUNDARY_IN | STRING_STEP_IN;
    // Only a rising level counts, so a held request is taken once.
    wire nmi_edge = NONMASKABLE_IRQ_IN & ~nmi_prev_ff;
    wire nmi_ready = nmi_pend_ff & ~nmi_active_ff;
    wire take_exc = idle & EXC_VALID_IN;
    wire take_return_from_interrupt = idle & ~EXC_VALID_IN & RETURN_FROM_INTERRUPT_IN;
    wire take_swi = idle & ~EXC_VALID_IN & ~RETURN_FROM_INTERRUPT_IN & SWI_VALID_IN;
    wire bnd_ok = idle & ~EXC_VALID_IN & ~RETURN_FROM_INTERRUPT_IN & ~SWI_VALID_IN & at_bnd;
    wire take_dbgt = bnd_ok & DBG_TRAP_IN;
    wire take_dbgf = bnd_ok & ~DBG_TRAP_IN & DBG_FAULT_IN;
    wire ext_ok = bnd_ok & ~DBG_TRAP_IN & ~DBG_FAULT_IN;
    wire take_nmi = ext_ok & nmi_ready;
    wire int_ok = MASKABLE_IRQ_IN & if_ff;
    wire take_int = ext_ok & ~nmi_ready & int_ok;
    wire take_fetch = ext_ok & ~nmi_ready & ~int_ok & FETCH_FAULT_IN;
    // The unit waits in the acknowledge state for as long as the controller needs.
    wire take_ack = st_ff == ST_ACK & ACK_VALID_IN;

    // --------------------------------------------------------------
    // Nested fault while entering a handler
    // --------------------------------------------------------------
    // A fault other than a page fault met while entering a segment handler, or a page handler not yet re-entered, escalates
    // to a double fault; one met while entering the double-fault handler or a re-entered page handler stops the core.
    wire in_entry = st_ff == ST_ENTRY & EXC_VALID_IN;
    wire ent_pf = enter_vec_ff == `IEU_VEC_PAGE;
    wire new_pf = EXC_VECTOR_IN == `IEU_VEC_PAGE;
    wire ent_seg = enter_vec_ff >= `IEU_VEC_INVTSS & enter_vec_ff <= `IEU_VEC_GPF;
    wire ent_df = enter_vec_ff == `IEU_VEC_DOUBLE;
    wire pf_twice = in_entry & ent_pf & new_pf & ~pf_again_ff;
    wire go_shut = in_entry & (ent_df | (ent_pf & pf_again_ff));
    wire go_df = in_entry & ~go_shut & ((ent_pf & ~new_pf) | (ent_seg & ~new_pf));
    wire take_nest = in_entry & ~go_shut;

    wire dispatch = take_exc | take_swi | take_dbgt | take_dbgf | take_nmi |
                    take_fetch | take_ack | take_nest;

    wire [7:0] swi_vec = SWI_ONE_BYTE_IN ? `IEU_VEC_BREAK : SWI_VECTOR_IN;
    wire [7:0] disp_vec = take_exc ? EXC_VECTOR_IN :
                          take_swi ? swi_vec :
                          (take_dbgt | take_dbgf) ? `IEU_VEC_DEBUG :
                          take_nmi ? `IEU_VEC_NMI :
                          take_fetch ? FETCH_VECTOR_IN :
                          take_ack ? ACK_VECTOR_IN :
                          go_df ? `IEU_VEC_DOUBLE : EXC_VECTOR_IN;
    // Internally raised and nested exceptions restart the offending instruction; everything else, debug and fetch faults included, resumes after it.
    wire [31:0] disp_ret = (take_exc | take_nest) ? CUR_ADDR_IN : NEXT_ADDR_IN;
    wire ieu_class_type disp_cls = take_nmi ? CLS_NMI :
                                   take_ack ? CLS_MASKABLE_IRQ_IN :
                                   take_swi ? CLS_TRAP : cls_sel;
    wire [10:0] disp_off = PROT_MODE_IN ? {disp_vec, 3'h0} : {1'b0, disp_vec, 2'h0};

    ieu_classifier u_cls
    (
        .vector_in(disp_vec),
        .dbg_fault_in(take_dbgf),
        .class_out(cls_sel)
    );

    // --------------------------------------------------------------
    // Return-frame stack
    // --------------------------------------------------------------
    // The stack wraps silently; nesting deeper than its depth loses frames.
    assign frm.wr_en = dispatch;
    assign frm.wr_addr = sp_ff;
    assign frm.wr_data = '{ret_addr: disp_ret, if_flag: if_ff};
    assign frm.rd_addr = sp_ff - 3'h1;

    wire [2:0] nxt_sp = dispatch ? sp_ff + 3'h1 :
                        take_return_from_interrupt ? sp_ff - 3'h1 : sp_ff;
    wire nxt_if = dispatch ? 1'b0 :
                  (st_ff == ST_POP) ? frm.rd_data.if_flag :
                  SET_IF_IN ? 1'b1 :
                  CLEAR_IF_IN ? 1'b0 : if_ff;
    // A new edge sets the pending flag even in the cycle it is consumed.
    wire nxt_nmi_pend = nmi_edge | (nmi_pend_ff & ~take_nmi);
    wire nxt_nmi_active = take_nmi | (nmi_active_ff & st_ff != ST_POP);

    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE:
            begin
                if (take_int)
                begin
                    nxt_st = ST_ACK;
                end
                else if (dispatch)
                begin
                    nxt_st = ST_ENTRY;
                end
                else if (take_return_from_interrupt)
                begin
                    nxt_st = ST_POP;
                end
            end
            ST_ACK:
            begin
                if (take_ack)
                begin
                    nxt_st = ST_ENTRY;
                end
            end
            ST_ENTRY:
            begin
                if (go_shut)
                begin
                    nxt_st = ST_SHUT;
                end
                else if (ENTRY_DONE_IN & ~EXC_VALID_IN)
                begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_POP: nxt_st = ST_IDLE;
            ST_SHUT: nxt_st = ST_SHUT;
            default: nxt_st = ST_IDLE;
        endcase
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            st_ff <= ST_IDLE;
            if_ff <= 1'b0;
            nmi_prev_ff <= 1'b0;
            nmi_pend_ff <= 1'b0;
            nmi_active_ff <= 1'b0;
            pf_again_ff <= 1'b0;
            enter_vec_ff <= 8'h00;
            sp_ff <= 3'h0;
            shut_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            if_ff <= nxt_if;
            nmi_prev_ff <= NONMASKABLE_IRQ_IN;
            nmi_pend_ff <= nxt_nmi_pend;
            nmi_active_ff <= nxt_nmi_active;
            pf_again_ff <= pf_twice | (pf_again_ff & st_ff == ST_ENTRY);
            enter_vec_ff <= dispatch ? disp_vec : enter_vec_ff;
            sp_ff <= nxt_sp;
            shut_ff <= nxt_st == ST_SHUT;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            DISPATCH_OUT <= 1'b0;
            VECTOR_OUT <= 8'h00;
            CLASS_OUT <= CLS_FAULT;
            RETURN_ADDR_OUT <= 32'h0000_0000;
            TABLE_OFFSET_OUT <= 11'h000;
            INTA_OUT <= 1'b0;
            RESUME_OUT <= 1'b0;
            RESUME_ADDR_OUT <= 32'h0000_0000;
        end
        else
        begin
            DISPATCH_OUT <= dispatch;
            VECTOR_OUT <= dispatch ? disp_vec : VECTOR_OUT;
            CLASS_OUT <= dispatch ? disp_cls : CLASS_OUT;
            RETURN_ADDR_OUT <= dispatch ? disp_ret : RETURN_ADDR_OUT;
            TABLE_OFFSET_OUT <= dispatch ? disp_off : TABLE_OFFSET_OUT;
            INTA_OUT <= take_int;
            RESUME_OUT <= st_ff == ST_POP;
            RESUME_ADDR_OUT <= (st_ff == ST_POP) ? frm.rd_data.ret_addr : RESUME_ADDR_OUT;
        end
    end

    assign IRQ_ENABLE_OUT = if_ff;
    assign NMI_ACTIVE_OUT = nmi_active_ff;
    // Shutdown comes from its own flop, so the pin is clean while the state decodes.
    assign SHUTDOWN_OUT = shut_ff;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    nmi_vector_a: assert property (take_nmi |=> DISPATCH_OUT && VECTOR_OUT == 8'h02
        && CLASS_OUT == CLS_NMI && !INTA_OUT) else $error("nmi dispatch wrong");
    if_cleared_a: assert property (DISPATCH_OUT |-> !IRQ_ENABLE_OUT)
        else $error("enable flag not cleared on dispatch");
    nmi_nested_a: assert property (NMI_ACTIVE_OUT && !$past(take_nmi) |-> !take_nmi)
        else $error("nmi nested");
    maskable_irq_in_gate_a: assert property (INTA_OUT
        |-> $past(MASKABLE_IRQ_IN && if_ff && at_bnd))
        else $error("acknowledge without enabled request");
    fault_ret_a: assert property (take_exc ##1 CLASS_OUT == CLS_FAULT
        |-> RETURN_ADDR_OUT == $past(CUR_ADDR_IN)) else $error("fault return address");
    trap_ret_a: assert property (take_swi |=> CLASS_OUT == CLS_TRAP
        && RETURN_ADDR_OUT == $past(NEXT_ADDR_IN)) else $error("trap return address");
    nmi_first_a: assert property (ext_ok && nmi_ready && MASKABLE_IRQ_IN && if_ff
        |=> VECTOR_OUT == 8'h02 ##1 !INTA_OUT) else $error("maskable before nmi");
    resume_if_a: assert property (st_ff == ST_POP |=> RESUME_OUT
        && IRQ_ENABLE_OUT == $past(frm.rd_data.if_flag)) else $error("flag not restored");
    pf_reenter_a: assert property (pf_twice |=> VECTOR_OUT == 8'h0e
        && CLASS_OUT == CLS_FAULT && !SHUTDOWN_OUT) else $error("page fault not re-entered");
    nmi_once_a: assert property (NONMASKABLE_IRQ_IN [*3] ##0 !nmi_pend_ff
        |=> !nmi_pend_ff) else $error("held nmi taken twice");
    // Outcome checks: most look at the registered outputs one cycle after the decision; nmi_hold_a checks nmi_pend_ff, offset_a also $past(PROT_MODE_IN).
    df_abort_a: assert property (go_df |=> DISPATCH_OUT && VECTOR_OUT == 8'h08
        && CLASS_OUT == CLS_ABORT) else $error("double fault not raised");
    shut_hold_a: assert property (SHUTDOWN_OUT |=> SHUTDOWN_OUT && !DISPATCH_OUT)
        else $error("shutdown left without reset");
    ack_vec_a: assert property (take_ack |=> DISPATCH_OUT && CLASS_OUT == CLS_MASKABLE_IRQ_IN
        && VECTOR_OUT == $past(ACK_VECTOR_IN)) else $error("acknowledge vector lost");
    dbg_trap_a: assert property (take_dbgt |=> VECTOR_OUT == 8'h01
        && CLASS_OUT == CLS_TRAP) else $error("debug trap class");
    dbg_fault_a: assert property (take_dbgf |=> VECTOR_OUT == 8'h01
        && CLASS_OUT == CLS_FAULT) else $error("debug fault class");
    fetch_vec_a: assert property (take_fetch |=> VECTOR_OUT == $past(FETCH_VECTOR_IN)
        && RETURN_ADDR_OUT == $past(NEXT_ADDR_IN)) else $error("fetch fault dispatch");
    nmi_if_a: assert property (take_nmi |=> !IRQ_ENABLE_OUT && NMI_ACTIVE_OUT)
        else $error("enable flag kept on nmi entry");
    nmi_hold_a: assert property (nmi_edge && nmi_active_ff |=> nmi_pend_ff)
        else $error("nmi during service lost");
    swi_break_a: assert property (take_swi && SWI_ONE_BYTE_IN |=> VECTOR_OUT == 8'h03)
        else $error("breakpoint vector");
    offset_a: assert property (DISPATCH_OUT |-> TABLE_OFFSET_OUT ==
        ($past(PROT_MODE_IN) ? {VECTOR_OUT, 3'h0} : {1'b0, VECTOR_OUT, 2'h0}))
        else $error("table offset");
    return_from_interrupt_pop_a: assert property (take_return_from_interrupt |=> st_ff == ST_POP ##1 RESUME_OUT)
        else $error("return not resumed");
    int_wait_a: assert property (take_int |=> INTA_OUT && !DISPATCH_OUT)
        else $error("maskable dispatched before acknowledge");
    mask_block_a: assert property (!IRQ_ENABLE_OUT |=> !INTA_OUT)
        else $error("acknowledge while masked");
endmodule // ieu_dispatch_unit

// File: shared/ieu_params.svh
// Constants of the interrupt and exception dispatch unit.
`ifndef IEU_PARAMS_SVH
`define IEU_PARAMS_SVH
`define IEU_NUM_VECTORS 256
`define IEU_RSVD_VECTORS 32
`define IEU_FREE_VECTORS 224
`define IEU_VEC_DEBUG 8'h01
`define IEU_VEC_NMI 8'h02
`define IEU_VEC_BREAK 8'h03
`define IEU_VEC_DOUBLE 8'h08
`define IEU_VEC_INVTSS 8'h0a
`define IEU_VEC_GPF 8'h0d
`define IEU_VEC_PAGE 8'h0e
`define IEU_FAULT_MASK 32'h00017ce1
`define IEU_ABORT_MASK 32'h00000300
`define IEU_FRAME_DEPTH 8
`define IEU_FRAME_AW 3
`endif

// File: shared/ieu_pkg.sv
// Types of the interrupt and exception dispatch unit.
package ieu_pkg;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_ACK = 3'h1,
        ST_ENTRY = 3'h2,
        ST_POP = 3'h3,
        ST_SHUT = 3'h4
    } ieu_state_type;
    typedef enum logic [2:0]
    {
        CLS_FAULT = 3'h0,
        CLS_TRAP = 3'h1,
        CLS_ABORT = 3'h2,
        CLS_MASKABLE_IRQ_IN = 3'h3,
        CLS_NMI = 3'h4
    } ieu_class_type;
    typedef struct packed
    {
        logic [31:0] ret_addr;
        logic if_flag;
    } ieu_frame_type;
endpackage

// File: shared/ieu_frame_if.sv
// Write and read signals between the dispatcher and its return-frame store.
`timescale 1ns/1ps
interface ieu_frame_if;
    import ieu_pkg::*;
    logic wr_en;
    logic [2:0] wr_addr;
    ieu_frame_type wr_data;
    logic [2:0] rd_addr;
    ieu_frame_type rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// File: core/ieu_frame_store.sv
// Small memory holding the saved return frames, read data registered.
`timescale 1ns/1ps
`include "ieu_params.svh"
module ieu_frame_store import ieu_pkg::*;
(
    input wire logic clk_in,
    ieu_frame_if.store frm
);
    ieu_frame_type mem_ff [0:`IEU_FRAME_DEPTH-1];
    ieu_frame_type rd_data_ff;

    always_ff @(posedge clk_in)
    begin
        if (frm.wr_en)
        begin
            mem_ff[frm.wr_addr] <= frm.wr_data;
        end
        rd_data_ff <= mem_ff[frm.rd_addr];
    end

    assign frm.rd_data = rd_data_ff;
endmodule // ieu_frame_store

// File: core/ieu_classifier.sv
// Maps an internally raised vector onto its exception class.
`timescale 1ns/1ps
`include "ieu_params.svh"
module ieu_classifier import ieu_pkg::*;
(
    input wire logic [7:0] vector_in,
    input wire logic dbg_fault_in,
    output ieu_class_type class_out
);
    localparam logic [31:0] FAULT_MASK = `IEU_FAULT_MASK;
    localparam logic [31:0] ABORT_MASK = `IEU_ABORT_MASK;
    localparam logic [8:0] RSVD = 9'(`IEU_RSVD_VECTORS);

    wire in_rsvd = {1'b0, vector_in} < RSVD;
    wire is_fault = in_rsvd & FAULT_MASK[vector_in[4:0]];
    wire is_abort = in_rsvd & ABORT_MASK[vector_in[4:0]];
    wire is_debug = vector_in == `IEU_VEC_DEBUG;

    // Vectors above the reserved range and the unused reserved ones are traps.
    assign class_out = is_debug ? (dbg_fault_in ? CLS_FAULT : CLS_TRAP) :
                       is_abort ? CLS_ABORT :
                       is_fault ? CLS_FAULT : CLS_TRAP;
endmodule // ieu_classifier

// File: dv/ieu_pic_model.sv
// Interrupt controller model that answers acknowledge sequences with a vector.
`timescale 1ns/1ps
module ieu_pic_model
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Bench control
    input wire logic req_in,
    input wire logic [7:0] vec_in,
    input wire logic [3:0] lat_in,
    // Acknowledge interface
    input wire logic inta_in,
    output logic irq_out,
    output logic ack_valid_out,
    output logic [7:0] ack_vector_out
);
    logic [7:0] vec_ff;
    logic [3:0] cnt_ff;
    logic wait_ff;

    // The vector bus toggles when idle, so a stale vector can never pass for a fresh one.
    always @(posedge clk_in)
    begin
        ack_valid_out <= 1'b0;
        ack_vector_out <= ~ack_vector_out;
        if (!rstn_in)
        begin
            irq_out <= 1'b0;
            wait_ff <= 1'b0;
            ack_vector_out <= 8'h5a;
        end
        else
        begin
            if (req_in)
            begin
                irq_out <= 1'b1;
                vec_ff <= vec_in;
            end
            if (inta_in)
            begin
                wait_ff <= 1'b1;
                cnt_ff <= lat_in;
            end
            else if (wait_ff && cnt_ff != 4'h0)
                cnt_ff <= cnt_ff - 4'h1;
            else if (wait_ff)
            begin
                ack_valid_out <= 1'b1;
                ack_vector_out <= vec_ff;
                irq_out <= 1'b0;
                wait_ff <= 1'b0;
            end
        end
    end
endmodule // ieu_pic_model

// File: dv/ieu_dispatch_unit_tb_top.sv
// Self-checking testbench of the interrupt and exception dispatch unit.
`timescale 1ns/1ps
module ieu_dispatch_unit_tb_top import ieu_pkg::*;
;
    logic clk_in, rstn, boundary, str_step, prot, entry_done, return_from_interrupt, set_if, clr_if;
    logic exc_v, swi_v, swi_one, dbg_trap, dbg_fault, fetch_f, nmi, pic_req, irq, ack_v;
    logic inta, disp, irq_en, nmi_act, resume, shut;
    logic [31:0] cur_addr, next_addr, ret_o, res_o;
    logic [7:0] exc_vec, swi_vec, fetch_vec, pic_vec, ack_vec, vec_o;
    logic [3:0] pic_lat;
    logic [10:0] toff;
    ieu_class_type cls_o;
    int bad_count = 0;
    int total_checks = 0;

    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    ieu_pic_model pic_u (.clk_in(clk_in), .rstn_in(rstn), .req_in(pic_req), .vec_in(pic_vec),
        .lat_in(pic_lat), .inta_in(inta), .irq_out(irq), .ack_valid_out(ack_v),
        .ack_vector_out(ack_vec));

    ieu_dispatch_unit dut_u (.CLK_IN(clk_in), .RSTN_IN(rstn), .BOUNDARY_IN(boundary),
        .STRING_STEP_IN(str_step), .CUR_ADDR_IN(cur_addr), .NEXT_ADDR_IN(next_addr),
        .PROT_MODE_IN(prot), .ENTRY_DONE_IN(entry_done), .RETURN_FROM_INTERRUPT_IN(return_from_interrupt), .SET_IF_IN(set_if),
        .CLEAR_IF_IN(clr_if), .EXC_VALID_IN(exc_v), .EXC_VECTOR_IN(exc_vec),
        .SWI_VALID_IN(swi_v), .SWI_ONE_BYTE_IN(swi_one), .SWI_VECTOR_IN(swi_vec),
        .DBG_TRAP_IN(dbg_trap), .DBG_FAULT_IN(dbg_fault), .FETCH_FAULT_IN(fetch_f),
        .FETCH_VECTOR_IN(fetch_vec), .MASKABLE_IRQ_IN(irq), .NONMASKABLE_IRQ_IN(nmi),
        .ACK_VALID_IN(ack_v), .ACK_VECTOR_IN(ack_vec), .INTA_OUT(inta), .DISPATCH_OUT(disp),
        .VECTOR_OUT(vec_o), .CLASS_OUT(cls_o), .RETURN_ADDR_OUT(ret_o),
        .TABLE_OFFSET_OUT(toff), .IRQ_ENABLE_OUT(irq_en), .NMI_ACTIVE_OUT(nmi_act),
        .RESUME_OUT(resume), .RESUME_ADDR_OUT(res_o), .SHUTDOWN_OUT(shut));

    task close_out;
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // All tasks start and end on a falling edge, so inputs never move on a sampling edge.
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_in);
        s = 1'b0;
    endtask

    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 12 && s !== 1'b1; i++)
            @(negedge clk_in);
        chk(s, 1'b1);
        if (s !== 1'b1)
            close_out();
    endtask

    task automatic quiet(ref logic s);
        for (int i = 0; i < 5; i++)
        begin
            chk(s, 1'b0);
            @(negedge clk_in);
        end
    endtask

    task disp_is(input logic [7:0] v, input ieu_class_type c, input logic [31:0] a);
        wait_hi(disp);
        chk(vec_o, v);
        chk(cls_o, c);
        chk(ret_o, a);
        chk(irq_en, 1'b0);
    endtask

    task chk_idle;
        chk(shut, 1'b0);
        chk(irq_en, 1'b0);
        chk(nmi_act, 1'b0);
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task sc_faults;
        for (int v = 0; v < 17; v++)
        begin
            if (v inside {[1:4], 15})
                continue;
            cur_addr = 32'h0000_2000 + v;
            prot = v[0];
            exc_vec = v[7:0];
            pulse(exc_v);
            disp_is(v[7:0], (v inside {8, 9}) ? CLS_ABORT : CLS_FAULT, cur_addr);
            chk(cls_o == CLS_ABORT, v inside {8, 9});
            chk(ret_o, 32'h0000_2000 + v);
            chk(toff, prot ? v * 8 : v * 4);
            pulse(entry_done);
        end
    endtask

    task sc_swi;
        next_addr = 32'h0000_3008;
        swi_vec = 8'hff;
        prot = 1'b1;
        pulse(swi_v);
        disp_is(8'hff, CLS_TRAP, next_addr);
        chk(toff, 32'h7f8);
        pulse(entry_done);
        swi_one = 1'b1;
        pulse(swi_v);
        disp_is(8'h03, CLS_TRAP, next_addr);
        swi_one = 1'b0;
        pulse(entry_done);
    endtask

    task sc_mask;
        pic_vec = 8'h40;
        pic_lat = 4'h3;
        pulse(pic_req);
        pulse(set_if);
        pulse(clr_if);
        chk(irq_en, 1'b0);
        pulse(boundary);
        quiet(inta);
        pulse(set_if);
        chk(irq_en, 1'b1);
        next_addr = 32'h0000_4010;
        pulse(str_step);
        wait_hi(inta);
        disp_is(8'h40, CLS_MASKABLE_IRQ_IN, next_addr);
        pulse(entry_done);
        next_addr = 32'h0000_4020;
        pulse(return_from_interrupt);
        wait_hi(resume);
        chk(res_o, 32'h0000_4010);
        chk(irq_en, 1'b1);
    endtask

    task sc_nmi;
        nmi = 1'b1;
        @(negedge clk_in);
        pulse(boundary);
        disp_is(8'h02, CLS_NMI, next_addr);
        chk(nmi_act, 1'b1);
        chk(inta, 1'b0);
        pulse(entry_done);
        pulse(boundary);
        quiet(disp);
        nmi = 1'b0;
        @(negedge clk_in);
        nmi = 1'b1;
        @(negedge clk_in);
        pulse(boundary);
        quiet(disp);
        pulse(return_from_interrupt);
        wait_hi(resume);
        chk(nmi_act, 1'b0);
        pulse(boundary);
        disp_is(8'h02, CLS_NMI, next_addr);
        pulse(entry_done);
        nmi = 1'b0;
        pulse(return_from_interrupt);
        wait_hi(resume);
    endtask

    task sc_both;
        pulse(set_if);
        pic_vec = 8'h51;
        pic_lat = 4'h0;
        pulse(pic_req);
        nmi = 1'b1;
        @(negedge clk_in);
        pulse(boundary);
        disp_is(8'h02, CLS_NMI, next_addr);
        pulse(entry_done);
        pulse(boundary);
        quiet(inta);
        pulse(return_from_interrupt);
        wait_hi(resume);
        pulse(boundary);
        wait_hi(inta);
        disp_is(8'h51, CLS_MASKABLE_IRQ_IN, next_addr);
        pulse(entry_done);
        nmi = 1'b0;
    endtask

    task sc_debug;
        {dbg_trap, dbg_fault, fetch_f} = 3'h7;
        fetch_vec = 8'h0e;
        pulse(boundary);
        disp_is(8'h01, CLS_TRAP, next_addr);
        dbg_trap = 1'b0;
        pulse(entry_done);
        pulse(boundary);
        disp_is(8'h01, CLS_FAULT, next_addr);
        dbg_fault = 1'b0;
        pulse(entry_done);
        pulse(boundary);
        disp_is(8'h0e, CLS_FAULT, next_addr);
        fetch_f = 1'b0;
        pulse(entry_done);
    endtask

    task sc_double;
        cur_addr = 32'h0000_6000;
        exc_vec = 8'h0d;
        pulse(exc_v);
        disp_is(8'h0d, CLS_FAULT, cur_addr);
        exc_vec = 8'h0b;
        pulse(exc_v);
        disp_is(8'h08, CLS_ABORT, cur_addr);
        chk(toff, 32'h040);
        pulse(entry_done);
    endtask

    task sc_page;
        cur_addr = 32'h0000_5000;
        exc_vec = 8'h0e;
        pulse(exc_v);
        disp_is(8'h0e, CLS_FAULT, cur_addr);
        pulse(exc_v);
        disp_is(8'h0e, CLS_FAULT, cur_addr);
        pulse(exc_v);
        wait_hi(shut);
        quiet(disp);
    endtask

    initial
    begin
        {rstn, boundary, str_step, prot, entry_done, return_from_interrupt, set_if, clr_if} = 8'h00;
        {exc_v, swi_v, swi_one, dbg_trap, dbg_fault, fetch_f, nmi, pic_req} = 8'h00;
        {exc_vec, swi_vec, fetch_vec, pic_vec, pic_lat} = 36'h0;
        cur_addr = 32'h0000_1000;
        next_addr = 32'h0000_1004;
        repeat (12) @(negedge clk_in);
        rstn = 1'b1;
        chk_idle();
        sc_faults();
        sc_swi();
        sc_mask();
        sc_nmi();
        sc_both();
        sc_debug();
        sc_double();
        sc_page();
        rstn = 1'b0;
        repeat (2) @(negedge clk_in);
        rstn = 1'b1;
        chk_idle();
        close_out();
    end
endmodule // ieu_dispatch_unit_tb_top
